// ==== src/qd_quadrature_decoder.sv ====
// quadrature decoder with index reset and per-line registers
`include "qd_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module qd_quadrature_decoder
   import qd_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [`QD_NUM_LINES-1:0] line_pin,
   input wire logic stream_mode,
   input wire qd_req_t req,
   output qd_rsp_t rsp,
   output logic [15:0] capture_hi
);
   localparam logic [`QD_SVC_W-1:0] SVC_LAST =
      `QD_SVC_W'(`QD_SVC_CYCLES - 1);

   logic [`QD_NUM_LINES-1:0] line_s;

   logic en_ff [`QD_NUM_LINES];
   logic [7:0] select_ff [`QD_NUM_LINES];
   logic [1:0] ictl_ff [`QD_NUM_LINES];
   logic [7:0] iline_ff [`QD_NUM_LINES];

   logic [31:0] count_ff [`QD_NUM_PAIRS];
   logic [31:0] err_ff [`QD_NUM_PAIRS];
   logic [31:0] err_snap_ff [`QD_NUM_PAIRS];
   logic [1:0] last_ff [`QD_NUM_PAIRS];
   logic act_d_ff [`QD_NUM_PAIRS];
   logic armed_ff [`QD_NUM_PAIRS];
   qd_svc_t svc_ff [`QD_NUM_PAIRS];
   logic [`QD_SVC_W-1:0] svc_cnt_ff [`QD_NUM_PAIRS];

   logic pair_act [`QD_NUM_PAIRS];
   logic pair_start [`QD_NUM_PAIRS];
   logic pair_rise [`QD_NUM_PAIRS];
   logic pair_zero [`QD_NUM_PAIRS];
   logic pair_clear [`QD_NUM_PAIRS];
   logic pair_capture [`QD_NUM_PAIRS];
   logic [1:0] pair_step [`QD_NUM_PAIRS];

   logic [31:0] rd_val;
   logic rd_int;
   logic [`QD_PAIR_W-1:0] rd_pair;
   logic rd_even;
   logic [31:0] pos_float;

   // step code from previous to current {b,a}: 01 up, 10 down, 11 lost
   function automatic logic [1:0] qd_step(input logic [1:0] prev,
                                          input logic [1:0] cur);
      logic [1:0] nxt_up;
      nxt_up = 2'h0;
      case (prev)
         2'h0: nxt_up = 2'h1;
         2'h1: nxt_up = 2'h3;
         2'h3: nxt_up = 2'h2;
         2'h2: nxt_up = 2'h0;
         default: nxt_up = 2'h0;
      endcase
      if (cur == prev) begin
         qd_step = 2'h0;
      end else if (cur == nxt_up) begin
         qd_step = 2'h1;
      end else if (cur == ~nxt_up) begin
         qd_step = 2'h2;
      end else begin
         qd_step = 2'h3;
      end
   endfunction : qd_step

   // level of the chosen index line; out-of-range numbers read low
   function automatic logic qd_index_high(input logic [7:0] num,
                                          input logic [`QD_NUM_LINES-1:0] lv);
      if (num[7:`QD_LINE_W] != '0) begin
         qd_index_high = 1'b0;
      end else begin
         qd_index_high = lv[num[`QD_LINE_W-1:0]];
      end
   endfunction : qd_index_high

   qd_sync u_sync (
      .clk(clk),
      .srst(srst),
      .async_in(line_pin),
      .sync_out(line_s)
   );

   qd_int_to_float u_float (
      .value(count_ff[rd_pair]),
      .result(pos_float)
   );

   // per-line configuration; result registers take no writes
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < `QD_NUM_LINES; i++) begin
            en_ff[i] <= `QD_RST_ENABLE;
            select_ff[i] <= `QD_RST_SELECT;
            ictl_ff[i] <= `QD_RST_INDEX_CTRL;
            iline_ff[i] <= `QD_RST_INDEX_LINE;
         end
      end else if (req.wr) begin
         case (req.sel)
            `QD_REG_ENABLE: en_ff[req.line] <= req.wdata[0];
            `QD_REG_SELECT: select_ff[req.line] <= req.wdata[7:0];
            `QD_REG_INDEX_CTRL: ictl_ff[req.line] <= req.wdata[1:0];
            `QD_REG_INDEX_LINE: iline_ff[req.line] <= req.wdata[7:0];
            default: ;
         endcase
      end
   end

   genvar p;
   generate
      for (p = 0; p < `QD_NUM_PAIRS; p++) begin : g_pair
         localparam int EV = 2 * p;
         localparam int OD = 2 * p + 1;
         logic [1:0] cur;
         logic [1:0] mode;

         // even line phase a in bit 0, odd line phase b in bit 1
         assign cur = {line_s[OD], line_s[EV]};
         assign mode = ictl_ff[EV];
         assign pair_act[p] = en_ff[EV] & en_ff[OD] &
            (select_ff[EV] == `QD_FEAT_QUAD) &
            (select_ff[OD] == `QD_FEAT_QUAD);
         assign pair_rise[p] = pair_act[p] & ~act_d_ff[p];
         // a change is taken only when no service is running
         assign pair_start[p] = pair_act[p] & act_d_ff[p] &
            (svc_ff[p] == SVC_IDLE) & (cur != last_ff[p]);
         assign pair_step[p] = qd_step(last_ff[p], cur);
         assign pair_zero[p] = pair_start[p] &
            qd_index_high(iline_ff[EV], line_s) &
            ((mode == `QD_IDX_ON) |
             ((mode == `QD_IDX_ONESHOT) & armed_ff[p]));
         assign pair_clear[p] = req.rd & (req.sel == `QD_REG_POS_CLEAR) &
            (req.line == `QD_LINE_W'(EV)) & pair_act[p];
         assign pair_capture[p] = req.rd & (req.line == `QD_LINE_W'(EV)) &
            ((req.sel == `QD_REG_POSITION) |
             (req.sel == `QD_REG_POS_FLOAT) |
             (req.sel == `QD_REG_POS_CLEAR));

         always_ff @(posedge clk) begin
            if (srst) begin
               act_d_ff[p] <= 1'b0;
            end else begin
               act_d_ff[p] <= pair_act[p];
            end
         end

         // service window: further changes wait until it ends, so a
         // double change shows as a skipped state, a triple can hide
         always_ff @(posedge clk) begin
            if (srst | ~pair_act[p]) begin
               svc_ff[p] <= SVC_IDLE;
               svc_cnt_ff[p] <= '0;
            end else begin
               case (svc_ff[p])
                  SVC_IDLE: begin
                     if (pair_start[p]) begin
                        svc_ff[p] <= SVC_BUSY;
                        svc_cnt_ff[p] <= '0;
                     end
                  end
                  SVC_BUSY: begin
                     if (svc_cnt_ff[p] == SVC_LAST) begin
                        svc_ff[p] <= SVC_IDLE;
                     end else begin
                        svc_cnt_ff[p] <= svc_cnt_ff[p] + 1'b1;
                     end
                  end
                  default: svc_ff[p] <= SVC_IDLE;
               endcase
            end
         end

         always_ff @(posedge clk) begin
            if (srst) begin
               last_ff[p] <= 2'h0;
            end else if (pair_rise[p] | pair_start[p]) begin
               last_ff[p] <= cur;
            end
         end

         // position: clears on enable, reset-read and index
         always_ff @(posedge clk) begin
            if (srst | pair_rise[p]) begin
               count_ff[p] <= `QD_RST_COUNT;
            end else if (pair_clear[p]) begin
               count_ff[p] <= `QD_RST_COUNT;
            end else if (pair_zero[p]) begin
               count_ff[p] <= `QD_RST_COUNT;
            end else if (pair_start[p] & (pair_step[p] == 2'h1)) begin
               count_ff[p] <= count_ff[p] + 32'h1;
            end else if (pair_start[p] & (pair_step[p] == 2'h2)) begin
               count_ff[p] <= count_ff[p] - 32'h1;
            end
         end

         always_ff @(posedge clk) begin
            if (srst | pair_rise[p]) begin
               err_ff[p] <= `QD_RST_ERRORS;
            end else if (pair_start[p] & (pair_step[p] == 2'h3)) begin
               err_ff[p] <= err_ff[p] + 32'h1;
            end
         end

         always_ff @(posedge clk) begin
            if (srst | pair_rise[p]) begin
               err_snap_ff[p] <= `QD_RST_ERRORS;
            end else if (pair_capture[p]) begin
               err_snap_ff[p] <= err_ff[p];
            end
         end

         // rearm beats consumption in the same cycle
         always_ff @(posedge clk) begin
            if (srst) begin
               armed_ff[p] <= 1'b0;
            end else if (pair_rise[p] | pair_clear[p]) begin
               armed_ff[p] <= 1'b1;
            end else if (pair_zero[p] & (mode == `QD_IDX_ONESHOT)) begin
               armed_ff[p] <= 1'b0;
            end
         end
      end
   endgenerate

   // read mux; odd lines and idle pairs give zero results
   always_comb begin
      rd_val = 32'h0;
      rd_int = 1'b0;
      rd_pair = req.line[`QD_LINE_W-1:1];
      rd_even = ~req.line[0] & pair_act[rd_pair];
      case (req.sel)
         `QD_REG_ENABLE: rd_val = {31'h0, en_ff[req.line]};
         `QD_REG_SELECT: rd_val = {24'h0, select_ff[req.line]};
         `QD_REG_INDEX_CTRL: rd_val = {30'h0, ictl_ff[req.line]};
         `QD_REG_INDEX_LINE: rd_val = {24'h0, iline_ff[req.line]};
         `QD_REG_POSITION, `QD_REG_POS_CLEAR: begin
            rd_int = 1'b1;
            if (rd_even) begin
               rd_val = count_ff[rd_pair];
            end
         end
         `QD_REG_ERRORS: begin
            rd_int = 1'b1;
            if (rd_even) begin
               rd_val = err_snap_ff[rd_pair];
            end
         end
         `QD_REG_POS_FLOAT: begin
            if (rd_even) begin
               rd_val = pos_float;
            end
         end
         `QD_REG_CAPTURE_HI: rd_val = {16'h0, capture_hi};
         default: rd_val = 32'h0;
      endcase
   end

   // answer one cycle after the read
   always_ff @(posedge clk) begin
      if (srst) begin
         rsp <= '0;
      end else begin
         rsp.valid <= req.rd;
         if (req.rd & stream_mode & rd_int) begin
            rsp.data <= {16'h0, rd_val[15:0]};
         end else if (req.rd) begin
            rsp.data <= rd_val;
         end
      end
   end

   // upper half kept for the separate capture read
   always_ff @(posedge clk) begin
      if (srst) begin
         capture_hi <= 16'h0;
      end else if (req.rd & rd_int) begin
         capture_hi <= rd_val[31:16];
      end
   end
endmodule : qd_quadrature_decoder
`default_nettype wire

// ==== src/qd_defs.svh ====
// constants of the quadrature decoder: counts, register ids, timing
`ifndef QD_DEFS_SVH
`define QD_DEFS_SVH

`define QD_NUM_LINES 8
`define QD_NUM_PAIRS 4
`define QD_LINE_W 3
`define QD_PAIR_W 2

`define QD_FEAT_QUAD 8'h0a

`define QD_REG_ENABLE 4'h0
`define QD_REG_SELECT 4'h1
`define QD_REG_OPTIONS 4'h2
`define QD_REG_INDEX_CTRL 4'h3
`define QD_REG_INDEX_LINE 4'h4
`define QD_REG_CONFIG_C 4'h5
`define QD_REG_CONFIG_D 4'h6
`define QD_REG_POSITION 4'h7
`define QD_REG_ERRORS 4'h8
`define QD_REG_POS_FLOAT 4'h9
`define QD_REG_POS_CLEAR 4'ha
`define QD_REG_CAPTURE_HI 4'hb

`define QD_IDX_OFF 2'h0
`define QD_IDX_ON 2'h1
`define QD_IDX_ONESHOT 2'h3

`define QD_RST_ENABLE 1'b0
`define QD_RST_SELECT 8'h00
`define QD_RST_INDEX_CTRL 2'h0
`define QD_RST_INDEX_LINE 8'h00
`define QD_RST_COUNT 32'h0000_0000
`define QD_RST_ERRORS 32'h0000_0000

`define QD_SVC_TIME_NS 14000
`define QD_CLK_MHZ 50
`define QD_SVC_CYCLES ((`QD_SVC_TIME_NS * `QD_CLK_MHZ) / 1000)
`define QD_SVC_W 10

`endif

// ==== src/qd_pkg.sv ====
// types shared by the quadrature decoder files
`include "qd_defs.svh"
package qd_pkg;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [`QD_LINE_W-1:0] line;
      logic [3:0] sel;
      logic [31:0] wdata;
   } qd_req_t;

   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } qd_rsp_t;

   typedef enum logic [0:0] {SVC_IDLE, SVC_BUSY} qd_svc_t;
endpackage : qd_pkg

// ==== src/qd_sync.sv ====
// two-stage synchroniser for the input lines
`include "qd_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module qd_sync
   import qd_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [`QD_NUM_LINES-1:0] async_in,
   output logic [`QD_NUM_LINES-1:0] sync_out
);
   logic [`QD_NUM_LINES-1:0] meta_ff;

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_ff <= '0;
         sync_out <= '0;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule : qd_sync
`default_nettype wire

// ==== src/qd_int_to_float.sv ====
// signed 32-bit integer to single precision converter
`timescale 1ns/1ns
`default_nettype none
module qd_int_to_float
   import qd_pkg::*;
(
   input wire logic [31:0] value,
   output logic [31:0] result
);
   logic sign;
   logic [31:0] mag;
   logic [31:0] norm;
   logic [4:0] msb;
   logic [7:0] expo;
   logic rnd;
   logic [31:0] body;

   // round to nearest even; above 2^24 the float loses counts
   always_comb begin
      sign = value[31];
      mag = sign ? (32'h0 - value) : value;
      msb = 5'h00;
      for (int i = 0; i < 32; i++) begin
         if (mag[i]) begin
            msb = 5'(i);
         end
      end
      norm = mag << (5'd31 - msb);
      expo = 8'h7f + {3'h0, msb};
      rnd = norm[7] & ((|norm[6:0]) | norm[8]);
      body = {1'b0, expo, norm[30:8]} + {31'h0, rnd};
      if (mag == 32'h0) begin
         result = 32'h0;
      end else begin
         result = {sign, body[30:0]};
      end
   end
endmodule : qd_int_to_float
`default_nettype wire

// ==== verification/qd_monitor.sv ====
// register port assertions for the quadrature decoder
`include "qd_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module qd_monitor
   import qd_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [`QD_NUM_LINES-1:0] line_pin,
   input wire logic stream_mode,
   input wire qd_req_t req,
   input wire qd_rsp_t rsp,
   input wire logic [15:0] capture_hi
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic int_rd;
   assign int_rd = req.rd && req.sel inside {4'h7, 4'h8, 4'ha};
   sequence s_wr(s);
      req.wr && req.sel == s;
   endsequence
   sequence s_rd_back(s);
      req.rd && req.sel == s && req.line == $past(req.line);
   endsequence
   property p_rsp_after_rd;
      req.rd |=> rsp.valid;
   endproperty
   a_rsp_after_rd: assert property (p_rsp_after_rd)
      else $error("read gave no answer");
   property p_no_stray;
      rsp.valid |-> $past(req.rd);
   endproperty
   a_no_stray: assert property (p_no_stray)
      else $error("answer without a read");
   property p_odd_zero;
      req.rd && req.line[0] && req.sel inside {[4'h7:4'ha]}
         |=> rsp.data == 32'h0;
   endproperty
   a_odd_zero: assert property (p_odd_zero)
      else $error("odd line result not zero");
   property p_stream_low;
      int_rd && stream_mode |=> rsp.data[31:16] == 16'h0;
   endproperty
   a_stream_low: assert property (p_stream_low)
      else $error("stream read upper half not zero");
   property p_data_hold;
      !req.rd |=> $stable(rsp.data);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("read data moved without a read");
   property p_cap_hold;
      !int_rd |=> $stable(capture_hi);
   endproperty
   a_cap_hold: assert property (p_cap_hold)
      else $error("capture half moved without a read");
   property p_en_back;
      s_wr(4'h0) ##1 s_rd_back(4'h0)
         |=> rsp.data == {31'h0, $past(req.wdata[0], 2)};
   endproperty
   a_en_back: assert property (p_en_back)
      else $error("enable readback wrong");
   property p_idx_back;
      s_wr(4'h3) ##1 s_rd_back(4'h3)
         |=> rsp.data == {30'h0, $past(req.wdata[1:0], 2)};
   endproperty
   a_idx_back: assert property (p_idx_back)
      else $error("index control readback wrong");
endmodule : qd_monitor
bind qd_quadrature_decoder qd_monitor qd_monitor_i (.clk(clk), .srst(srst),
   .line_pin(line_pin), .stream_mode(stream_mode), .req(req), .rsp(rsp),
   .capture_hi(capture_hi));
`default_nettype wire

// ==== verification/qd_encoder_model.sv ====
// incremental encoder: two phases in gray order and an index line
`timescale 1ns/1ns
`default_nettype none
module qd_encoder_model (
   input wire logic clk,
   input wire logic step,
   input wire logic dir,
   input wire logic z_en,
   output logic a,
   output logic b,
   output logic z
);
   logic [1:0] ph_ff = 2'h0;
   // one quarter cycle per request; spacing is the caller's duty
   always @(posedge clk) begin
      if (step) begin
         ph_ff <= dir ? ph_ff - 2'h1 : ph_ff + 2'h1;
      end
   end
   assign a = ^ph_ff;
   assign b = ph_ff[1];
   // index held wide so it spans whole edges
   assign z = z_en;
endmodule : qd_encoder_model
`default_nettype wire

// ==== verification/qd_quadrature_decoder_test.sv ====
// self-checking bench for the quadrature decoder
`timescale 1ns/1ns
`default_nettype none
module qd_quadrature_decoder_test import qd_pkg::*;;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic stream_mode = 1'b0;
   logic step = 1'b0;
   logic dir = 1'b0;
   logic z_en = 1'b0;
   logic a, b, z;
   logic [4:0] rnd = 5'h0;
   qd_req_t req = '0;
   qd_rsp_t rsp;
   logic [15:0] capture_hi;
   logic [31:0] eq[$];
   string nq[$];
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   initial begin
      forever #10 clk = ~clk;
   end
   qd_encoder_model qd_encoder_model_i (.clk(clk), .step(step), .dir(dir),
      .z_en(z_en), .a(a), .b(b), .z(z));
   qd_quadrature_decoder qd_quadrature_decoder_i (.clk(clk), .srst(srst),
      .line_pin({b, a, z, rnd}), .stream_mode(stream_mode), .req(req),
      .rsp(rsp), .capture_hi(capture_hi));
   task automatic check(input logic [31:0] seen, exp, input string nm);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wr(input int l, s, input logic [31:0] d);
      @(negedge clk);
      req <= '{1'b0, 1'b1, l[2:0], s[3:0], d};
      @(negedge clk);
      req <= '0;
   endtask : wr
   task automatic rd(input int l, s, input logic [31:0] e, input string nm);
      eq.push_back(e);
      nq.push_back(nm);
      @(negedge clk);
      req <= '{1'b1, 1'b0, l[2:0], s[3:0], 32'h0};
      @(negedge clk);
      req <= '0;
   endtask : rd
   // write then read back on the very next edge
   task automatic wr_rd(input int l, s, input logic [31:0] d, e,
                        input string nm);
      eq.push_back(e);
      nq.push_back(nm);
      @(negedge clk);
      req <= '{1'b0, 1'b1, l[2:0], s[3:0], d};
      @(negedge clk);
      req <= '{1'b1, 1'b0, l[2:0], s[3:0], 32'h0};
      @(negedge clk);
      req <= '0;
   endtask : wr_rd
   // edges g+2 cycles apart; a spacing under 701 finds the decoder still busy
   task automatic mv(input logic d, input int k, g);
      repeat (k) begin
         @(negedge clk);
         step <= 1'b1;
         dir <= d;
         rnd <= 5'($urandom);
         @(negedge clk);
         step <= 1'b0;
         repeat (g) @(negedge clk);
      end
   endtask : mv
   task automatic done(input string nm);
      $display("test %s over, %0d mismatches", nm, mismatches);
   endtask : done
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end
      else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   // answers are one-cycle pulses, so look at every falling edge
   always @(negedge clk) begin
      if (rsp.valid === 1'b1) begin
         if (eq.size() == 0) begin
            eq.push_back(32'hx);
            nq.push_back("stray answer");
         end
         check(rsp.data, eq.pop_front(), nq.pop_front());
      end
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches++;
         close_out();
      end
   end
   initial begin
      void'($urandom(32'h0daf1213));
      repeat (3) @(negedge clk);
      srst <= 1'b0;
      for (int l = 6; l < 8; l++) begin
         wr(l, 0, 32'h0);
         wr(l, 1, 32'h0a);
         wr(l, 4, 32'h5);
      end
      rd(6, 1, 32'h0a, "feature select");
      rd(6, 7, 32'h0, "count while off");
      wr(6, 0, 32'h1);
      wr_rd(7, 0, 32'h1, 32'h1, "feature enable");
      done("config");
      n = 1 + $urandom % 8;
      mv(1'b0, n, 720);
      rd(6, 7, n, "count forward");
      mv(1'b1, n + 2, 720);
      rd(6, 7, 32'hffff_fffe, "count reverse");
      rd(6, 9, 32'hc000_0000, "float count");
      rd(6, 8, 32'h0, "error count");
      rd(7, 7, 32'h0, "odd line count");
      rd(2, 7, 32'h0, "idle pair count");
      done("direction");
      stream_mode <= 1'b1;
      rd(6, 7, 32'h0000_fffe, "stream low half");
      check({16'h0, capture_hi}, 32'h0000_ffff, "high half");
      rd(6, 11, 32'h0000_ffff, "capture read");
      stream_mode <= 1'b0;
      rd(6, 10, 32'hffff_fffe, "clear on read");
      rd(6, 7, 32'h0, "count after clear");
      done("stream and clear");
      wr_rd(6, 3, 32'h1, 32'h1, "index control");
      z_en <= 1'b1;
      mv(1'b0, 2, 720);
      rd(6, 7, 32'h0, "index clear");
      wr(6, 3, 32'h3);
      mv(1'b0, 3, 720);
      rd(6, 10, 32'h2, "one-shot count");
      mv(1'b0, 3, 720);
      rd(6, 7, 32'h2, "rearmed count");
      done("index");
      wr(6, 3, 32'h0);
      mv(1'b1, 2, 10);
      mv(1'b1, 1, 720);
      rd(6, 8, 32'h0, "stale error count");
      rd(6, 7, 32'h1, "count after close edges");
      rd(6, 8, 32'h1, "error count");
      wr(6, 7, 32'h55);
      rd(6, 7, 32'h1, "count after result write");
      done("errors");
      repeat (4) @(negedge clk);
      close_out();
   end
endmodule : qd_quadrature_decoder_test
`default_nettype wire
